/* src/flash_status_register_bank.sv */
// Purpose: status registers of a serial flash behind its serial pins
// Assumes: serial mode 0, link pins sampled by core_clk
// Notes:   array engine is outside; its error events come in on core_clk
//
// How it works
// RULE1 - Register one bit 7 and register two bit 0 pick status write protection.
// RULE2 - Register one bit 6 anchors protection at top (0) or bottom (1).
// RULE3 - Register one bits 5..2 hold the range; zero protects nothing.
// RULE4 - Write latch flag, read only; without it no program, erase, status write.
// RULE5 - Busy flag, read only; one while an embedded operation runs.
// RULE6 - Register two bit 7 reads one while an erase is suspended.
// RULE7 - Register two bit 6 picks normal or inverted protection map.
// RULE8 - Register two bits 5..3 are set-only locks for security registers 3..1.
// RULE9 - Register two bit 2 reads one while a program is suspended.
// RULE10 - Quad enable turns write protect and shared pins into data lines.
// RULE11 - Register three bit 7 picks hold or reset, only without quad.
// RULE12 - Register three bits 6..5 pick read output drive strength.
// RULE13 - Erase fail flag set on erase failure or protected erase attempt.
// RULE14 - Program fail flag set on program failure or protected program attempt.
// RULE15 - Register three bit 2 picks range protection or individual locks.
// RULE16 - Register three bit 1 gives address width taken at power up.
// RULE17 - Register three bit 0 shows current address width, read only.
// RULE18 - While busy, only status reads are obeyed; the code also obeys suspend while a program or erase runs.
// RULE19 - Busy clears when the operation completes.
// RULE20 - Write enable sets the latch; disable, program, erase, status write clear it.
// RULE21 - Resume, software reset and power cycle clear both suspend flags.
// RULE22 - Hardware protection with write protect pin low refuses status writes.
// RULE23 - Host polls busy until zero before other instructions.
`timescale 1ns/100ps
`include "flash_status_consts.svh"
module flash_status_register_bank import flash_status_pkg::*; (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Serial pins
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       di,
	input  wire logic       wp_n,
	input  wire logic       hold_reset_n,
	output      logic       so_data,
	output      logic       so_oe_n,
	// Array engine events
	input  wire logic       erase_error_event,
	input  wire logic       program_error_event,
	// Configuration out
	output      logic       busy,
	output      logic       write_latch_flag,
	output      logic       protect_from_bottom,
	output      logic [3:0] protect_range,
	output      logic       invert_protect_map,
	output      logic [3:1] otp_lock,
	output      logic       quad_io_enable,
	output      logic       hold_fn_en,
	output      logic       reset_fn_en,
	output      logic [1:0] drive_strength,
	output      logic       protect_scheme_select,
	output      logic       current_addr_width
);

	// ****************************************
	// Pin sampling
	// ****************************************
	logic [4:0] pins_s;
	logic       sclk_s;
	logic       cs_n_s;
	logic       di_s;
	logic       wp_n_s;
	logic       hold_s;
	logic       sclk_d;
	logic       cs_n_d;
	logic       cs_on_s;
	logic       wp_on_s;
	logic       hold_on_s;

	// Low pins go in inverted, so the zero reset of the flops reads as idle
	pin_sync #(.WIDTH(5)) u_sync (
		.core_clk     (core_clk),
		.nrst         (nrst),
		.pin_in       ({sclk, ~cs_n, di, ~wp_n, ~hold_reset_n}),
		.pin_sync_out (pins_s)
	);

	assign {sclk_s, cs_on_s, di_s, wp_on_s, hold_on_s} = pins_s;
	assign cs_n_s = ~cs_on_s;
	assign wp_n_s = ~wp_on_s;
	assign hold_s = ~hold_on_s;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_d <= 1'b0;
			cs_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_n_d <= cs_n_s;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic frame_end;
	assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
	assign frame_end = cs_n_s & ~cs_n_d;

	// ****************************************
	// Frame shifter
	// ****************************************
	logic [5:0] bit_count;
	logic [7:0] shift_in;
	logic [7:0] cmd;
	logic [7:0] wr_data;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bit_count <= 6'h00;
			shift_in  <= 8'h00;
			cmd       <= 8'h00;
			wr_data   <= 8'h00;
		end else if (cs_n_s) begin
			bit_count <= 6'h00;
		end else if (sclk_rise) begin
			shift_in <= {shift_in[6:0], di_s};
			if (bit_count != 6'h3F)
				bit_count <= bit_count + 6'h01;
			if (bit_count == 6'h07)
				cmd <= {shift_in[6:0], di_s};
			if (bit_count == 6'h0F)
				wr_data <= {shift_in[6:0], di_s};
		end
	end

	// ****************************************
	// Stored fields
	// ****************************************
	logic       status_lock_mode_lo;
	logic       status_lock_mode_hi;
	logic       shared_pin_select;
	logic       powerup_addr_width;
	logic       erase_paused;
	logic       program_paused;
	logic       erase_fail_flag;
	logic       program_fail_flag;
	logic       reset_armed;
	op_t        op_state;
	logic [11:0] op_count;

	// Status byte assembly, used by reads and by checks
	function automatic logic [7:0] status_byte(input logic [1:0] sel);
		case (sel)
			2'd0: status_byte = {status_lock_mode_lo, protect_from_bottom, protect_range,
				write_latch_flag, busy};
			2'd1: status_byte = {erase_paused, invert_protect_map, otp_lock,
				program_paused, quad_io_enable, status_lock_mode_hi};
			default: status_byte = {shared_pin_select, drive_strength, erase_fail_flag,
				program_fail_flag, protect_scheme_select, powerup_addr_width,
				current_addr_width};
		endcase
	endfunction

	// ****************************************
	// Command decode at frame end
	// ****************************************
	lock_mode_t lock_mode;
	logic       status_locked;
	logic [5:0] addr_bits;
	logic       opc_frame;
	logic       do_wren;
	logic       do_wrdi;
	logic       do_wsr;
	logic [1:0] wsr_sel;
	logic       do_prog;
	logic       do_erase;
	logic       do_suspend;
	logic       do_resume;
	logic       do_reset;
	logic       do_enter4;
	logic       do_exit4;
	logic       pin_reset;
	logic       soft_reset;

	assign lock_mode = lock_mode_t'({status_lock_mode_hi, status_lock_mode_lo}); // [RULE1]
	// Write protect pin only counts while it is not a data line
	assign status_locked = (lock_mode == LOCK_HARDWARE && !wp_n_s && !quad_io_enable)
		|| lock_mode == LOCK_POWER_DOWN || lock_mode == LOCK_ONE_TIME; // [RULE22]
	assign addr_bits = current_addr_width ? `BITS_ADDR4 : `BITS_ADDR3;
	assign opc_frame = frame_end && bit_count == `BITS_OPCODE;

	// While busy only reads and suspend act; reads need no frame end [RULE18]
	assign do_wren  = opc_frame && !busy && cmd == `OPC_WRITE_ENABLE;
	assign do_wrdi  = opc_frame && !busy && cmd == `OPC_WRITE_DISABLE;
	assign do_wsr   = frame_end && bit_count == `BITS_STATUS_WRITE && !busy
		&& write_latch_flag && !status_locked
		&& (cmd == `OPC_WRITE_SR1 || cmd == `OPC_WRITE_SR2 || cmd == `OPC_WRITE_SR3); // [RULE4]
	assign wsr_sel  = (cmd == `OPC_WRITE_SR1) ? 2'd0 : (cmd == `OPC_WRITE_SR2) ? 2'd1 : 2'd2;
	assign do_prog  = frame_end && !busy && write_latch_flag && cmd == `OPC_PAGE_PROGRAM
		&& bit_count >= `BITS_OPCODE + addr_bits + `BITS_OPCODE; // [RULE4]
	assign do_erase = frame_end && !busy && write_latch_flag
		&& (((cmd == `OPC_SECTOR_ERASE || cmd == `OPC_BLOCK_ERASE)
		&& bit_count == `BITS_OPCODE + addr_bits) || (opc_frame && cmd == `OPC_CHIP_ERASE));
	// Suspend is the one instruction that must reach a running program or erase
	assign do_suspend = opc_frame && cmd == `OPC_SUSPEND
		&& (op_state == OP_PROGRAM || op_state == OP_ERASE) && busy;
	assign do_resume  = opc_frame && !busy && cmd == `OPC_RESUME
		&& (erase_paused || program_paused);
	assign do_reset   = opc_frame && !busy && cmd == `OPC_RESET && reset_armed;
	assign do_enter4  = opc_frame && !busy && cmd == `OPC_ENTER_4BYTE;
	assign do_exit4   = opc_frame && !busy && cmd == `OPC_EXIT_4BYTE;
	assign pin_reset  = reset_fn_en && !hold_s;
	assign soft_reset = do_reset || pin_reset;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			reset_armed <= 1'b0;
		else if (opc_frame && !busy)
			reset_armed <= cmd == `OPC_RESET_ENABLE;
		else if (frame_end)
			reset_armed <= 1'b0;
	end

	// ****************************************
	// Configuration fields
	// ****************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			{status_lock_mode_lo, protect_from_bottom, protect_range} <= 6'(`SR1_RESET >> 2);
			{invert_protect_map, otp_lock, quad_io_enable, status_lock_mode_hi} <= 6'h00;
			{shared_pin_select, drive_strength} <= 3'h0;
			{protect_scheme_select, powerup_addr_width} <= 2'h0;
		end else if (soft_reset) begin
			// Power supply lock down is lifted by a reset
			if (lock_mode == LOCK_POWER_DOWN) begin
				status_lock_mode_lo <= 1'b0;
				status_lock_mode_hi <= 1'b0;
			end
		end else if (do_wsr) begin
			case (wsr_sel)
				2'd0: begin
					status_lock_mode_lo <= wr_data[`SR1_LOCK_LO]; // [RULE1]
					protect_from_bottom <= wr_data[`SR1_FROM_BOTTOM]; // [RULE2]
					protect_range <= wr_data[`SR1_RANGE_HI:`SR1_RANGE_LO]; // [RULE3]
				end
				2'd1: begin
					invert_protect_map  <= wr_data[`SR2_INVERT_MAP]; // [RULE7]
					// Locks can only be set, never cleared
					otp_lock <= otp_lock | wr_data[`SR2_OTP_HI:`SR2_OTP_LO]; // [RULE8]
					quad_io_enable      <= wr_data[`SR2_QUAD]; // [RULE10]
					status_lock_mode_hi <= wr_data[`SR2_LOCK_HI]; // [RULE1]
				end
				default: begin
					shared_pin_select <= wr_data[`SR3_SHARED_PIN]; // [RULE11]
					drive_strength <= wr_data[`SR3_DRIVE_HI:`SR3_DRIVE_LO]; // [RULE12]
					protect_scheme_select <= wr_data[`SR3_SCHEME]; // [RULE15]
					powerup_addr_width <= wr_data[`SR3_POWERUP_ADDR]; // [RULE16]
				end
			endcase
		end
	end

	// Pin roles, registered so ports come from flops
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hold_fn_en  <= 1'b0;
			reset_fn_en <= 1'b0;
		end else begin
			hold_fn_en  <= !quad_io_enable && !shared_pin_select; // [RULE10] [RULE11]
			reset_fn_en <= !quad_io_enable && shared_pin_select; // [RULE10] [RULE11]
		end
	end

	// ****************************************
	// Write latch
	// ****************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			write_latch_flag <= 1'b0;
		else if (soft_reset || do_wrdi || do_prog || do_erase || do_wsr)
			write_latch_flag <= 1'b0; // [RULE20]
		else if (do_wren)
			write_latch_flag <= 1'b1; // [RULE20]
	end

	// ****************************************
	// Embedded operation timer
	// ****************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			op_state       <= OP_IDLE;
			op_count       <= 12'h000;
			busy           <= 1'b0;
			erase_paused   <= 1'b0;
			program_paused <= 1'b0;
		end else if (soft_reset) begin
			op_state       <= OP_IDLE;
			busy           <= 1'b0;
			erase_paused   <= 1'b0; // [RULE21]
			program_paused <= 1'b0; // [RULE21]
		end else if (do_suspend) begin
			busy           <= 1'b0;
			erase_paused   <= op_state == OP_ERASE; // [RULE6]
			program_paused <= op_state == OP_PROGRAM; // [RULE9]
		end else if (busy) begin
			if (op_count == 12'h001) begin
				busy     <= 1'b0; // [RULE19]
				op_state <= OP_IDLE;
			end
			op_count <= op_count - 12'h001;
		end else if (do_resume) begin
			// Remaining count was held through the pause
			busy           <= 1'b1;
			erase_paused   <= 1'b0; // [RULE21]
			program_paused <= 1'b0; // [RULE21]
		end else if (do_prog || do_erase || do_wsr) begin
			busy <= 1'b1; // [RULE5]
			case (1'b1)
				do_prog: begin
					op_state <= OP_PROGRAM;
					op_count <= 12'(`CYC_PROGRAM);
				end
				do_erase: begin
					op_state <= OP_ERASE;
					op_count <= 12'(`CYC_ERASE);
				end
				default: begin
					op_state <= OP_STATUS;
					op_count <= 12'(`CYC_WRITE_STATUS);
				end
			endcase
		end
	end

	// ****************************************
	// Error flags and address width
	// ****************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			erase_fail_flag   <= 1'b0;
			program_fail_flag <= 1'b0;
		end else begin
			// A new event wins over the clear in the same cycle
			erase_fail_flag <= erase_error_event
				|| (erase_fail_flag && !do_resume && !soft_reset); // [RULE13]
			program_fail_flag <= program_error_event
				|| (program_fail_flag && !do_resume && !soft_reset); // [RULE14]
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			current_addr_width <= 1'b0;
		else if (soft_reset)
			current_addr_width <= powerup_addr_width; // [RULE16] [RULE17]
		else if (do_enter4)
			current_addr_width <= 1'b1; // [RULE17]
		else if (do_exit4)
			current_addr_width <= 1'b0; // [RULE17]
	end

	// ****************************************
	// Status read output
	// ****************************************
	logic       rd_active;
	logic [1:0] rd_sel;
	logic [7:0] rd_now;
	assign rd_active = bit_count >= `BITS_OPCODE
		&& (cmd == `OPC_READ_SR1 || cmd == `OPC_READ_SR2 || cmd == `OPC_READ_SR3);
	assign rd_sel = (cmd == `OPC_READ_SR1) ? 2'd0 : (cmd == `OPC_READ_SR2) ? 2'd1 : 2'd2;

	// Process, not assign: the function reads fields that are not its arguments
	always_comb begin
		rd_now = status_byte(rd_sel);
	end

	// Live value: each new byte shows the latest busy state [RULE18] [RULE23]
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			so_data <= 1'b0;
			so_oe_n <= 1'b1;
		end else if (cs_n_s) begin
			so_oe_n <= 1'b1;
		end else if (sclk_fall && rd_active) begin
			so_oe_n <= 1'b0;
			so_data <= rd_now[3'd7 - bit_count[2:0]];
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	logic [7:0] sr1_now;
	logic [7:0] sr2_now;
	logic [7:0] sr3_now;
	always_comb begin
		sr1_now = status_byte(2'd0);
		sr2_now = status_byte(2'd1);
		sr3_now = status_byte(2'd2);
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_start_needs_latch;
		$rose(busy) && !$past(do_resume) |-> $past(write_latch_flag);
	endproperty
	a_start_needs_latch: assert property (p_start_needs_latch) // [RULE4]
		else $error("operation started without write latch");

	property p_latch_set;
		do_wren |=> write_latch_flag;
	endproperty
	a_latch_set: assert property (p_latch_set) // [RULE20]
		else $error("write enable did not set latch");

	property p_latch_clear;
		do_wrdi || do_wsr |=> !write_latch_flag ##1 !write_latch_flag || $past(do_wren);
	endproperty
	a_latch_clear: assert property (p_latch_clear) // [RULE20]
		else $error("latch not cleared");

	property p_busy_ends;
		do_wsr |=> busy [*8] ##[1:300] !busy;
	endproperty
	a_busy_ends: assert property (p_busy_ends) // [RULE19]
		else $error("status write busy time wrong");

	property p_busy_ignores;
		busy && frame_end && !do_suspend && !pin_reset |=> $stable(sr1_now[7:1])
			&& $stable(sr2_now) && $stable(sr3_now[7:5]) && $stable(sr3_now[2:0]);
	endproperty
	a_busy_ignores: assert property (p_busy_ignores) // [RULE18]
		else $error("instruction obeyed while busy");

	property p_locked_refuses;
		frame_end && status_locked && !soft_reset |=> $stable(sr1_now[7:2])
			&& $stable({sr2_now[6:3], sr2_now[1:0]}) && $stable(sr3_now[7:5])
			&& $stable(sr3_now[2:1]);
	endproperty
	a_locked_refuses: assert property (p_locked_refuses) // [RULE22]
		else $error("status written while locked");

	property p_resume_clears;
		do_resume |=> !erase_paused && !program_paused && busy;
	endproperty
	a_resume_clears: assert property (p_resume_clears) // [RULE21]
		else $error("resume left suspend flag");

	property p_suspend_flags;
		do_suspend |=> !busy && (erase_paused ^ program_paused);
	endproperty
	a_suspend_flags: assert property (p_suspend_flags) // [RULE6] [RULE9]
		else $error("suspend flags wrong");

	property p_otp_sticky;
		otp_lock[1] |=> otp_lock[1];
	endproperty
	a_otp_sticky: assert property (p_otp_sticky) // [RULE8]
		else $error("security lock cleared");

	property p_quad_pins;
		quad_io_enable ##1 quad_io_enable |-> !hold_fn_en && !reset_fn_en;
	endproperty
	a_quad_pins: assert property (p_quad_pins) // [RULE10] [RULE11]
		else $error("pin function active in quad mode");

	property p_err_set;
		erase_error_event |=> erase_fail_flag;
	endproperty
	a_err_set: assert property (p_err_set) // [RULE13]
		else $error("erase error lost");

	property p_addr_mode;
		do_enter4 |=> current_addr_width ##1 current_addr_width || busy || soft_reset
			|| $past(do_exit4) || $past(soft_reset);
	endproperty
	a_addr_mode: assert property (p_addr_mode) // [RULE17]
		else $error("four byte mode not entered");

	c_status_write: cover property (do_wsr ##[1:300] !busy);
	c_suspend_resume: cover property (do_suspend ##[1:1000] do_resume);
	c_read_busy: cover property (busy && !so_oe_n);
	c_locked_write: cover property (frame_end && status_locked && write_latch_flag);

endmodule

/* src/flash_status_consts.svh */
// Purpose: constants of the flash status register bank
// Assumes: core clock figure in MHz, times in ns
// Notes:   definitions only
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define CORE_CLK_MHZ          100
`define T_WRITE_STATUS_NS     2000
`define T_PROGRAM_NS          3000
`define T_ERASE_NS            40000
// Least times, rounded up to whole cycles
`define CYC_WRITE_STATUS      ((`T_WRITE_STATUS_NS * `CORE_CLK_MHZ + 999) / 1000)
`define CYC_PROGRAM           ((`T_PROGRAM_NS * `CORE_CLK_MHZ + 999) / 1000)
`define CYC_ERASE             ((`T_ERASE_NS * `CORE_CLK_MHZ + 999) / 1000)

// ****************************************
// Instruction codes
// ****************************************
`define OPC_WRITE_ENABLE      8'h06
`define OPC_WRITE_DISABLE     8'h04
`define OPC_READ_SR1          8'h05
`define OPC_READ_SR2          8'h35
`define OPC_READ_SR3          8'h15
`define OPC_WRITE_SR1         8'h01
`define OPC_WRITE_SR2         8'h31
`define OPC_WRITE_SR3         8'h11
`define OPC_PAGE_PROGRAM      8'h02
`define OPC_SECTOR_ERASE      8'h20
`define OPC_BLOCK_ERASE       8'hD8
`define OPC_CHIP_ERASE        8'hC7
`define OPC_SUSPEND           8'h75
`define OPC_RESUME            8'h7A
`define OPC_RESET_ENABLE      8'h66
`define OPC_RESET             8'h99
`define OPC_ENTER_4BYTE       8'hB7
`define OPC_EXIT_4BYTE        8'hE9

// ****************************************
// Frame and address field lengths in serial clocks
// ****************************************
`define BITS_OPCODE           6'd8
`define BITS_STATUS_WRITE     6'd16
`define BITS_ADDR3            6'd24
`define BITS_ADDR4            6'd32

// ****************************************
// Field positions
// ****************************************
`define SR1_LOCK_LO           7
`define SR1_FROM_BOTTOM       6
`define SR1_RANGE_HI          5
`define SR1_RANGE_LO          2
`define SR2_INVERT_MAP        6
`define SR2_OTP_HI            5
`define SR2_OTP_LO            3
`define SR2_QUAD              1
`define SR2_LOCK_HI           0
`define SR3_SHARED_PIN        7
`define SR3_DRIVE_HI          6
`define SR3_DRIVE_LO          5
`define SR3_SCHEME            2
`define SR3_POWERUP_ADDR      1

// ****************************************
// Reset values
// ****************************************
`define SR1_RESET             8'h00
`define SR2_RESET             8'h00
`define SR3_RESET             8'h00

`endif

/* src/flash_status_pkg.sv */
// Purpose: types of the flash status register bank
// Assumes: nothing
// Notes:   constants live in the header
package flash_status_pkg;

	// Embedded operation in progress or suspended
	typedef enum logic [1:0] {
		OP_IDLE,
		OP_PROGRAM,
		OP_ERASE,
		OP_STATUS
	} op_t;

	// Protection method from the two lock mode bits
	typedef enum logic [1:0] {
		LOCK_SOFTWARE,
		LOCK_HARDWARE,
		LOCK_POWER_DOWN,
		LOCK_ONE_TIME
	} lock_mode_t;

endpackage

/* src/pin_sync.sv */
// Purpose: two-flop synchroniser for pins
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             nrst,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] pin_in,
	output      logic [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stage1       <= '0;
			pin_sync_out <= '0;
		end else begin
			stage1       <= pin_in;
			pin_sync_out <= stage1;
		end
	end

endmodule

/* tb/spi_host_model.sv */
// Purpose: serial host model issuing status frames
// Assumes: mode 0, 160 ns link period, clock idle low
// Notes:   data line inverted when idle, it has no pull
`timescale 1ns/100ps
module spi_host_model (
	// Link pins
	output logic       sclk,
	output logic       cs_n,
	output logic       di,
	input  wire logic  so_data,
	// Read result
	output logic       rd_valid,
	output logic [7:0] rd_byte
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		di = 1'b0;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
	end

	// ****************
	// One frame, MSB first
	// ****************
	// Clock stands still between frames; cs high 80 ns after the last clock, then 100 ns wait
	task automatic frame(input logic [15:0] bits, input int nb, input bit rd);
		cs_n = 1'b0;
		for (int i = 0; i < nb + (rd ? 8 : 0); i++) begin
			if (i < nb)
				di = bits[15-i];
			#80 sclk = 1'b1;
			if (i >= nb)
				rd_byte = {rd_byte[6:0], so_data};
			#80 sclk = 1'b0;
		end
		#80 cs_n = 1'b1;
		di = ~di;
		#100;
		if (rd) begin
			rd_valid = 1'b1;
			#10 rd_valid = 1'b0;
		end
	endtask
endmodule

/* tb/flash_status_register_bank_tb.sv */
// Purpose: self-checking bench of the status register bank
// Assumes: host model drives the link pins
// Notes:   error events and write protect driven here
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value %0t: %h not %h", $time, a, b); end end
module flash_status_register_bank_tb;
	logic       core_clk, nrst, sclk, cs_n, di, wp_n, hold_reset_n, so_data, so_oe_n;
	logic       erase_error_event, program_error_event, busy, write_latch_flag;
	logic       protect_from_bottom, invert_protect_map, quad_io_enable, hold_fn_en;
	logic       reset_fn_en, protect_scheme_select, current_addr_width, rd_valid;
	logic [3:0] protect_range;
	logic [3:1] otp_lock;
	logic [1:0] drive_strength;
	logic [7:0] rd_byte, d, e;
	logic [7:0] exp_q[$];
	int         err_count = 0, compares = 0, seed = 32'h8c29;

	flash_status_register_bank u_dut (
		.core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .di(di), .wp_n(wp_n),
		.hold_reset_n(hold_reset_n), .so_data(so_data), .so_oe_n(so_oe_n),
		.erase_error_event(erase_error_event), .program_error_event(program_error_event),
		.busy(busy), .write_latch_flag(write_latch_flag),
		.protect_from_bottom(protect_from_bottom), .protect_range(protect_range),
		.invert_protect_map(invert_protect_map), .otp_lock(otp_lock),
		.quad_io_enable(quad_io_enable), .hold_fn_en(hold_fn_en), .reset_fn_en(reset_fn_en),
		.drive_strength(drive_strength), .protect_scheme_select(protect_scheme_select),
		.current_addr_width(current_addr_width));
	spi_host_model m (.sclk(sclk), .cs_n(cs_n), .di(di), .so_data(so_data),
		.rd_valid(rd_valid), .rd_byte(rd_byte));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ****************
	// Tasks
	// ****************
	task automatic cmd(input logic [7:0] op, input logic [7:0] dt, input int nb);
		@(posedge core_clk);
		#1 m.frame({op, dt}, nb, 0);
	endtask
	task automatic rd(input logic [7:0] op, input logic [7:0] ex);
		exp_q.push_back(ex);
		@(posedge core_clk);
		#1 m.frame({op, 8'h00}, 8, 1);
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 5000 && busy !== 1'b0; i++) begin
			@(posedge core_clk);
			#1;
		end
		`CHK(busy, 1'b0)
	endtask
	task automatic wrap_up;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Read results come back in issue order
	always @(posedge rd_valid) begin
		e = exp_q.pop_front();
		`CHK(rd_byte, e)
	end

	initial begin
		#400000 err_count++;
		wrap_up;
	end

	// ****************
	// Scenarios
	// ****************
	initial begin
		{nrst, erase_error_event, program_error_event} = 3'h0;
		{wp_n, hold_reset_n} = 2'h3;
		repeat (3) @(posedge core_clk);
		#1 nrst = 1'b1;
		repeat (5) @(posedge core_clk);
		rd(8'h05, 8'h00);
		rd(8'h35, 8'h00);
		rd(8'h15, 8'h00);
		cmd(8'h31, 8'h02, 16);
		`CHK(quad_io_enable, 1'b0)
		cmd(8'h06, 8'h00, 8);
		`CHK(write_latch_flag, 1'b1)
		d = 8'($random(seed)) & 8'h7C;
		cmd(8'h01, d, 16);
		`CHK({busy, write_latch_flag}, 2'h2)
		cmd(8'h06, 8'h00, 8);
		`CHK(write_latch_flag, 1'b0)
		wait_idle;
		`CHK({protect_from_bottom, protect_range}, d[6:2])
		rd(8'h05, d);
		cmd(8'h06, 8'h00, 8);
		cmd(8'h01, 8'h80, 16);
		wait_idle;
		wp_n = 1'b0;
		cmd(8'h06, 8'h00, 8);
		cmd(8'h01, 8'h3C, 16);
		`CHK(busy, 1'b0)
		rd(8'h05, 8'h82);
		wp_n = 1'b1;
		cmd(8'h01, 8'h00, 16);
		wait_idle;
		cmd(8'h06, 8'h00, 8);
		cmd(8'h11, 8'hE6, 16);
		wait_idle;
		`CHK({drive_strength, protect_scheme_select}, 3'h7)
		`CHK({reset_fn_en, hold_fn_en, current_addr_width}, 3'h4)
		cmd(8'hB7, 8'h00, 8);
		`CHK(current_addr_width, 1'b1)
		@(posedge core_clk);
		#1 {erase_error_event, program_error_event} = 2'h3;
		@(posedge core_clk);
		#1 {erase_error_event, program_error_event} = 2'h0;
		rd(8'h15, 8'hFF);
		cmd(8'h06, 8'h00, 8);
		cmd(8'hC7, 8'h00, 8);
		`CHK({busy, write_latch_flag}, 2'h2)
		cmd(8'h75, 8'h00, 8);
		`CHK(busy, 1'b0)
		rd(8'h35, 8'h80);
		cmd(8'h7A, 8'h00, 8);
		rd(8'h15, 8'hE7);
		rd(8'h35, 8'h00);
		wait_idle;
		cmd(8'h06, 8'h00, 8);
		cmd(8'h31, 8'h7A, 16);
		wait_idle;
		`CHK({invert_protect_map, otp_lock, quad_io_enable}, 5'h1F)
		`CHK({reset_fn_en, hold_fn_en}, 2'h0)
		rd(8'h35, 8'h7A);
		repeat (5) @(posedge core_clk);
		wrap_up;
	end
endmodule
